//--- pmil_event_latch.sv
`timescale 1ns/1ps

// Bank of latched-high flags; a set in the same cycle as a clear wins.
module pmil_event_latch #(
    parameter int W = 11
) (
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic [W-1:0] i_set,
    input wire logic [W-1:0] i_clr,
    output logic [W-1:0] o_q
);

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_q <= '0;
        end else begin
            o_q <= (o_q & ~i_clr) | i_set;
        end
    end

endmodule // pmil_event_latch

//--- pmil_mdio_master.sv
`timescale 1ns/1ps

// =====================================================================
// Management master that clocks frames into the device.
// =====================================================================
module pmil_mdio_master
    import pmil_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_dev_mdio,
    input wire logic i_dev_oe,
    output logic o_mdc,
    output logic o_mdio
);
    logic drv_oe;
    logic drv_d;

    // The line is pulled up whenever neither end drives it.
    assign o_mdio = i_dev_oe ? i_dev_mdio : (drv_oe ? drv_d : 1'b1);

    initial begin
        o_mdc = 1'b0;
        drv_oe = 1'b0;
        drv_d = 1'b0;
    end

    // The clock stands low between frames; each bit is three mclk low, four high.
    task automatic frame(input logic pre, input logic [1:0] op, input logic [4:0] phy,
                         input logic [4:0] rg, input logic [15:0] wd,
                         output logic [15:0] rd);
        logic [63:0] bits;
        int first;
        bits = {32'hffff_ffff, 2'h1, op, phy, rg, 2'h2, wd};
        first = pre ? 63 : 31;
        rd = 16'h0000;
        for (int i = first; i >= 0; i--) begin
            @(negedge i_mclk);
            o_mdc = 1'b0;
            drv_oe = !(op == PMIL_OP_READ && i < 18);
            drv_d = bits[i];
            repeat (3) @(negedge i_mclk);
            // The device moves to its next bit on the first mclk rise after each mdc rise, so sample first.
            if (i < 16) begin
                rd[i] = o_mdio;
            end
            o_mdc = 1'b1;
            repeat (3) @(negedge i_mclk);
        end
        @(negedge i_mclk);
        o_mdc = 1'b0;
        drv_oe = 1'b0;
    endtask
endmodule // pmil_mdio_master

//--- pmil_pkg.sv
package pmil_pkg;

    // =====================================================================
    // Management register numbers
    // =====================================================================
    localparam logic [4:0] PMIL_REG_PHY_CTRL = 5'h17;
    localparam logic [4:0] PMIL_REG_IRQ_MASK = 5'h18;
    localparam logic [4:0] PMIL_REG_IRQ_STAT = 5'h19;

    // =====================================================================
    // Field layout
    // =====================================================================
    localparam int PMIL_DATA_W = 16;
    localparam int PMIL_LATCH_W = 11;
    localparam int PMIL_BIT_PEND = 0;
    localparam int PMIL_BIT_PIN_EN = 0;
    localparam int PMIL_BIT_FORCE = 0;
    localparam int PMIL_BIT_SYNC_LOST = 9;
    localparam int PMIL_BIT_CABLE_DONE = 10;
    localparam int PMIL_EVT_LO = 1;
    localparam int PMIL_EVT_HI = 10;
    localparam logic [15:0] PMIL_MASK_WR_BITS = 16'h07ff;
    localparam logic [15:0] PMIL_MASK_RESET = 16'h0000;
    localparam logic [10:0] PMIL_STAT_RESET = 11'h000;
    localparam logic [15:0] PMIL_REG_ZERO = 16'h0000;

    // =====================================================================
    // Management frame encoding and bit counts
    // =====================================================================
    localparam logic [1:0] PMIL_OP_READ = 2'h2;
    localparam logic [1:0] PMIL_OP_WRITE = 2'h1;
    localparam logic [4:0] PMIL_PRE_LAST = 5'h1f;
    localparam logic [4:0] PMIL_OP_LAST = 5'h01;
    localparam logic [4:0] PMIL_ADDR_LAST = 5'h09;
    localparam logic [4:0] PMIL_TA_LAST = 5'h01;
    localparam logic [4:0] PMIL_DATA_LAST = 5'h0f;
    localparam logic [4:0] PMIL_CNT_ZERO = 5'h00;
    localparam logic [4:0] PMIL_CNT_ONE = 5'h01;

    typedef enum logic [2:0] {
        ST_HUNT  = 3'h0,
        ST_READY = 3'h1,
        ST_START = 3'h2,
        ST_OP    = 3'h3,
        ST_ADDR  = 3'h4,
        ST_TA    = 3'h5,
        ST_DATA  = 3'h6
    } pmil_state_t;

    typedef struct packed {
        logic [1:0] op;
        logic [4:0] phyad;
        logic [4:0] regad;
    } pmil_hdr_t;

endpackage

//--- pmil_top.sv
`timescale 1ns/1ps

// Functional notes
// - Mask register bits 10..1 enable their events; reset zero; bits 15..11 reserved.
// - Mask bit 0 enables the interrupt pin; cleared keeps pin deasserted unless the force bit is set.
// - With pin enabled, pin is low while pending flag is one.
// - Status bits 10..1 latch high on event, hold until cleared, reset zero.
// - Status bit 10 latches when cable test or phone detection finishes.
// - Status bit 0 latches when any latched event has its mask bit set.
// - Sync loss under preamble skipping latches status bit 9.
// - After sync loss, one full-preamble frame restores frame synchronisation.
// - Force bit in control register asserts pin regardless; clearing releases it.
module pmil_top
    import pmil_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic i_mdc,
    input wire logic i_mdio,
    output logic o_mdio,
    output logic o_mdio_oe,
    input wire logic [4:0] i_phy_addr,
    input wire logic i_preamble_skip_mode,
    input wire logic [PMIL_EVT_HI:PMIL_EVT_LO] i_events,
    output logic o_mgmt_irq_pin_n
);

    // =====================================================================
    // Register state
    // =====================================================================
    logic [15:0] interrupt_enable_mask;
    logic force_irq;
    logic [PMIL_LATCH_W-1:0] interrupt_event_status;
    logic [PMIL_LATCH_W-1:0] clr_vec;
    logic sync_lost;

    // =====================================================================
    // Management frame engine
    // =====================================================================
    pmil_state_t state;
    logic [4:0] cnt;
    logic [15:0] shreg;
    pmil_hdr_t hdr;
    logic mdc_q;

    function automatic logic [15:0] reg_read(input logic [4:0] regad,
                                             input logic [15:0] mask,
                                             input logic [PMIL_LATCH_W-1:0] stat,
                                             input logic frc);
        logic [15:0] val;
        val = PMIL_REG_ZERO;
        unique case (regad)
            PMIL_REG_PHY_CTRL: val[PMIL_BIT_FORCE] = frc;
            PMIL_REG_IRQ_MASK: val = mask;
            PMIL_REG_IRQ_STAT: val[PMIL_LATCH_W-1:0] = stat;
            default: val = PMIL_REG_ZERO;
        endcase
        return val;
    endfunction

    wire mdc_rise = i_mdc & ~mdc_q;
    wire [15:0] sh_next = {shreg[14:0], i_mdio};
    wire [1:0] op_next = sh_next[1:0];
    wire op_ok = (op_next == PMIL_OP_READ) || (op_next == PMIL_OP_WRITE);
    wire reg_mapped = (hdr.regad == PMIL_REG_PHY_CTRL) || (hdr.regad == PMIL_REG_IRQ_MASK) ||
                      (hdr.regad == PMIL_REG_IRQ_STAT);
    wire hit = (hdr.phyad == i_phy_addr) && reg_mapped;
    wire rd_hit = hit && (hdr.op == PMIL_OP_READ);
    wire wr_hit = hit && (hdr.op == PMIL_OP_WRITE);
    wire [15:0] rd_val = reg_read(hdr.regad, interrupt_enable_mask,
                                  interrupt_event_status, force_irq);
    wire start_bad = (state == ST_START) && mdc_rise && !i_mdio;
    wire op_bad = (state == ST_OP) && mdc_rise && (cnt == PMIL_OP_LAST) && !op_ok;
    wire frame_fault = start_bad || op_bad;
    wire ta_load = (state == ST_TA) && mdc_rise && (cnt == PMIL_TA_LAST) && rd_hit;
    wire data_end = (state == ST_DATA) && mdc_rise && (cnt == PMIL_DATA_LAST);
    wire wr_commit = data_end && wr_hit;
    wire stat_read = ta_load && (hdr.regad == PMIL_REG_IRQ_STAT);

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            mdc_q <= 1'b0;
        end else begin
            mdc_q <= i_mdc;
        end
    end

    // A fault under preamble skipping falls back to hunting for a full preamble.
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            state <= ST_HUNT;
            cnt <= PMIL_CNT_ZERO;
            shreg <= PMIL_REG_ZERO;
            hdr <= '0;
        end else if (mdc_rise) begin
            shreg <= sh_next;
            unique case (state)
                ST_HUNT: begin
                    if (!i_mdio) begin
                        cnt <= PMIL_CNT_ZERO;
                    end else if (cnt == PMIL_PRE_LAST) begin
                        state <= ST_READY;
                        cnt <= PMIL_CNT_ZERO;
                    end else begin
                        cnt <= cnt + PMIL_CNT_ONE;
                    end
                end
                ST_READY: begin
                    if (!i_mdio) begin
                        state <= ST_START;
                    end
                end
                ST_START: begin
                    state <= i_mdio ? ST_OP : ST_HUNT;
                    cnt <= PMIL_CNT_ZERO;
                end
                ST_OP: begin
                    if (cnt == PMIL_OP_LAST) begin
                        state <= op_ok ? ST_ADDR : ST_HUNT;
                        hdr.op <= op_next;
                        cnt <= PMIL_CNT_ZERO;
                    end else begin
                        cnt <= cnt + PMIL_CNT_ONE;
                    end
                end
                ST_ADDR: begin
                    if (cnt == PMIL_ADDR_LAST) begin
                        state <= ST_TA;
                        hdr.phyad <= sh_next[9:5];
                        hdr.regad <= sh_next[4:0];
                        cnt <= PMIL_CNT_ZERO;
                    end else begin
                        cnt <= cnt + PMIL_CNT_ONE;
                    end
                end
                ST_TA: begin
                    if (cnt == PMIL_TA_LAST) begin
                        state <= ST_DATA;
                        cnt <= PMIL_CNT_ZERO;
                        if (rd_hit) begin
                            shreg <= {rd_val[14:0], 1'b0};
                        end
                    end else begin
                        cnt <= cnt + PMIL_CNT_ONE;
                    end
                end
                ST_DATA: begin
                    if (cnt == PMIL_DATA_LAST) begin
                        state <= i_preamble_skip_mode ? ST_READY : ST_HUNT;
                        cnt <= PMIL_CNT_ZERO;
                    end else begin
                        cnt <= cnt + PMIL_CNT_ONE;
                    end
                end
                default: begin
                    state <= ST_HUNT;
                    cnt <= PMIL_CNT_ZERO;
                end
            endcase
        end
    end

    // The device drives the second turnaround bit low, then the data bits.
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_mdio <= 1'b0;
            o_mdio_oe <= 1'b0;
        end else if (mdc_rise) begin
            if ((state == ST_TA) && (cnt == PMIL_CNT_ZERO) && rd_hit) begin
                o_mdio <= 1'b0;
                o_mdio_oe <= 1'b1;
            end else if (ta_load) begin
                o_mdio <= rd_val[15];
            end else if (data_end) begin
                o_mdio <= 1'b0;
                o_mdio_oe <= 1'b0;
            end else if ((state == ST_DATA) && o_mdio_oe) begin
                o_mdio <= shreg[15];
            end
        end
    end

    // =====================================================================
    // Mask and force registers
    // =====================================================================
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            interrupt_enable_mask <= PMIL_MASK_RESET;
            force_irq <= 1'b0;
        end else if (wr_commit && (hdr.regad == PMIL_REG_IRQ_MASK)) begin
            interrupt_enable_mask <= sh_next & PMIL_MASK_WR_BITS;
        end else if (wr_commit && (hdr.regad == PMIL_REG_PHY_CTRL)) begin
            force_irq <= sh_next[PMIL_BIT_FORCE];
        end
    end

    // =====================================================================
    // Event latches and interrupt pin
    // =====================================================================
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            sync_lost <= 1'b0;
        end else begin
            sync_lost <= frame_fault && i_preamble_skip_mode;
        end
    end

    wire [PMIL_EVT_HI:PMIL_EVT_LO] evt_set = i_events |
        ((PMIL_EVT_HI - PMIL_EVT_LO + 1)'(sync_lost) << (PMIL_BIT_SYNC_LOST - PMIL_EVT_LO));
    // Bits being cleared by a read no longer count, so pending drops with its cause.
    wire [PMIL_LATCH_W-1:0] hold_vec = interrupt_event_status & ~clr_vec;
    wire pend_set = |(hold_vec[PMIL_EVT_HI:PMIL_EVT_LO] &
                      interrupt_enable_mask[PMIL_EVT_HI:PMIL_EVT_LO]);
    wire [PMIL_LATCH_W-1:0] set_vec = {evt_set, pend_set};
    assign clr_vec = stat_read ? interrupt_event_status : PMIL_STAT_RESET;

    pmil_event_latch #(
        .W(PMIL_LATCH_W)
    ) u_latch (
        .i_mclk(i_mclk),
        .i_nrst(i_nrst),
        .i_set(set_vec),
        .i_clr(clr_vec),
        .o_q(interrupt_event_status)
    );

    wire pin_on = force_irq ||
                  (interrupt_enable_mask[PMIL_BIT_PIN_EN] && interrupt_event_status[PMIL_BIT_PEND]);

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_mgmt_irq_pin_n <= 1'b1;
        end else begin
            o_mgmt_irq_pin_n <= !pin_on;
        end
    end

    // =====================================================================
    // Assertions
    // =====================================================================
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_nrst);

    sequence bad_start_s;
        ((state == ST_START) && !i_mdio ||
         (state == ST_OP) && (cnt == PMIL_OP_LAST) && !op_ok) &&
        mdc_rise && i_preamble_skip_mode;
    endsequence

    sequence sync_flag_s;
        ##1 sync_lost ##1 interrupt_event_status[PMIL_BIT_SYNC_LOST];
    endsequence

    mask_rsvd_a: assert property (interrupt_enable_mask[15:11] == 5'h00)
        else $error("Reserved mask bits are set.");
    pin_disable_a: assert property (!interrupt_enable_mask[PMIL_BIT_PIN_EN] && !force_irq
        |=> o_mgmt_irq_pin_n)
        else $error("Pin asserted while disabled.");
    pin_assert_a: assert property (interrupt_enable_mask[PMIL_BIT_PIN_EN] &&
        interrupt_event_status[PMIL_BIT_PEND] |=> !o_mgmt_irq_pin_n)
        else $error("Pin not asserted with pending flag.");
    event_hold_a: assert property (##1 ((interrupt_event_status & $past(hold_vec))
        == $past(hold_vec)))
        else $error("Latched event bit dropped without a read.");
    cable_done_a: assert property (i_events[PMIL_BIT_CABLE_DONE]
        |=> interrupt_event_status[PMIL_BIT_CABLE_DONE])
        else $error("Cable test completion not latched.");
    pend_set_a: assert property (pend_set |=> interrupt_event_status[PMIL_BIT_PEND])
        else $error("Pending flag not set.");
    sync_lost_a: assert property (bad_start_s |-> sync_flag_s)
        else $error("Sync loss not latched.");
    resync_a: assert property ((state == ST_HUNT) && mdc_rise && i_mdio &&
        (cnt == PMIL_PRE_LAST) |=> (state == ST_READY) ##1 (cnt == PMIL_CNT_ZERO))
        else $error("Full preamble did not restore sync.");
    force_pin_a: assert property (force_irq |=> !o_mgmt_irq_pin_n)
        else $error("Force bit did not assert pin.");
    read_clear_a: assert property (stat_read && !set_vec[1] && clr_vec[1]
        |=> !interrupt_event_status[1])
        else $error("Status bit not cleared by read.");

endmodule // pmil_top

//--- pmil_top_test.sv
`timescale 1ns/1ps

module pmil_top_test
    import pmil_pkg::*;
;
    localparam logic [4:0] PHY = 5'h05;
    localparam logic [4:0] OTHER = 5'h06;
    logic i_mclk;
    logic i_nrst;
    logic mdc, mdio_line, dev_mdio, dev_oe, skip, pin_n;
    logic [PMIL_EVT_HI:PMIL_EVT_LO] events;
    logic [15:0] rdata;
    int mismatches;
    int num_checks;

    pmil_top dut (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_mdc(mdc), .i_mdio(mdio_line),
        .o_mdio(dev_mdio), .o_mdio_oe(dev_oe), .i_phy_addr(PHY),
        .i_preamble_skip_mode(skip), .i_events(events), .o_mgmt_irq_pin_n(pin_n));

    pmil_mdio_master master (.i_mclk(i_mclk), .i_dev_mdio(dev_mdio), .i_dev_oe(dev_oe),
        .o_mdc(mdc), .o_mdio(mdio_line));

    // =====================================================================
    // Shared tasks
    // =====================================================================
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t ns: got %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        if (mismatches == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [4:0] rg, input logic [15:0] d);
        master.frame(1'b1, PMIL_OP_WRITE, PHY, rg, d, rdata);
    endtask

    task automatic rd(input logic [4:0] rg, input logic [15:0] exp);
        master.frame(1'b1, PMIL_OP_READ, PHY, rg, 16'h0000, rdata);
        check(rdata, exp);
    endtask

    task automatic pulse(input int k);
        @(negedge i_mclk);
        events[k] = 1'b1;
        @(negedge i_mclk);
        events = 10'h000;
    endtask

    task automatic pin(input logic exp);
        repeat (4) @(negedge i_mclk);
        check({15'h0000, pin_n}, {15'h0000, exp});
    endtask

    // =====================================================================
    // Clock, watchdog and test sequence
    // =====================================================================
    initial begin
        i_mclk = 1'b0;
        forever #4 i_mclk = ~i_mclk;
    end

    initial begin
        repeat (60000) @(posedge i_mclk);
        mismatches++;
        summarize();
    end

    initial begin
        i_nrst = 1'b0;
        skip = 1'b0;
        events = 10'h000;
        repeat (16) @(negedge i_mclk);
        i_nrst = 1'b1;
        repeat (2) @(negedge i_mclk);
        check({15'h0000, pin_n}, 16'h0001);
        rd(PMIL_REG_IRQ_MASK, PMIL_MASK_RESET);
        rd(PMIL_REG_IRQ_STAT, 16'h0000);
        rd(PMIL_REG_PHY_CTRL, 16'h0000);
        wr(PMIL_REG_IRQ_MASK, 16'hffff);
        rd(PMIL_REG_IRQ_MASK, 16'h07ff);
        pin(1'b1);
        wr(PMIL_REG_IRQ_MASK, 16'h0000);
        for (int k = PMIL_EVT_LO; k <= PMIL_EVT_HI; k++) begin
            pulse(k);
            pin(1'b1);
            rd(PMIL_REG_IRQ_STAT, 16'h0001 << k);
            rd(PMIL_REG_IRQ_STAT, 16'h0000);
        end
        wr(PMIL_REG_IRQ_MASK, 16'h0004);
        pulse(2);
        pin(1'b1);
        rd(PMIL_REG_IRQ_STAT, 16'h0005);
        wr(PMIL_REG_IRQ_MASK, 16'h0005);
        pulse(4);
        pin(1'b1);
        pulse(2);
        pin(1'b0);
        rd(PMIL_REG_IRQ_STAT, 16'h0015);
        pin(1'b1);
        // A level event is still present across reads and keeps its bit.
        events[3] = 1'b1;
        wr(PMIL_REG_IRQ_MASK, 16'h0009);
        rd(PMIL_REG_IRQ_STAT, 16'h0009);
        rd(PMIL_REG_IRQ_STAT, 16'h0009);
        pin(1'b0);
        events = 10'h000;
        rd(PMIL_REG_IRQ_STAT, 16'h0009);
        rd(PMIL_REG_IRQ_STAT, 16'h0000);
        pin(1'b1);
        wr(PMIL_REG_IRQ_MASK, 16'h0000);
        wr(PMIL_REG_PHY_CTRL, 16'hffff);
        pin(1'b0);
        rd(PMIL_REG_PHY_CTRL, 16'h0001);
        wr(PMIL_REG_PHY_CTRL, 16'h0000);
        pin(1'b1);
        master.frame(1'b1, PMIL_OP_WRITE, OTHER, PMIL_REG_IRQ_MASK, 16'h0003, rdata);
        master.frame(1'b1, PMIL_OP_READ, OTHER, PMIL_REG_IRQ_MASK, 16'h0000, rdata);
        check(rdata, 16'hffff);
        rd(PMIL_REG_IRQ_MASK, 16'h0000);
        // Preamble skipping: a bad opcode loses sync until a full preamble.
        skip = 1'b1;
        wr(PMIL_REG_IRQ_MASK, 16'h0201);
        master.frame(1'b0, PMIL_OP_READ, PHY, PMIL_REG_IRQ_MASK, 16'h0000, rdata);
        check(rdata, 16'h0201);
        master.frame(1'b0, 2'h3, PHY, PMIL_REG_IRQ_MASK, 16'h0000, rdata);
        pin(1'b0);
        master.frame(1'b0, PMIL_OP_READ, PHY, PMIL_REG_IRQ_MASK, 16'h0000, rdata);
        check(rdata, 16'hffff);
        rd(PMIL_REG_IRQ_STAT, 16'h0201);
        summarize();
    end
endmodule // pmil_top_test
